/* rtl/pm_cap_regs.sv */
// Summary of operation
// - Identifier byte always reads 01h, the power-management entry code; writes ignored.
// - Next-capability link byte always reads zero; only one entry exists.
// - Capabilities word holds FE12h after global reset.
// - Wake-source mask bits 15..11 read all ones by default.
// - Bits 14..11 are fixed ones: wake from hot-D3, D2, D1 and D0.
// - Bit 15 is writable, defaults one; firmware clears it without auxiliary power.
// - Only global reset restores bit 15; other resets leave it alone.
// - Bit 10 always reads one: D2 state supported.
// - Bit 9 always reads one: D1 state supported.
// - Reserved bits 8..6 always read zero.
// - Bit 5, device-specific initialization needed, always reads zero.
// - Bit 4 shows auxiliary supply need, and reads zero whenever bit 15 is zero.
// - Bit 3 reads zero: wake signalling needs no bus clock.
// - Bits 2..0 read 010b: revision and four bytes of registers.
`timescale 1ns/100ps
`default_nettype none

module pm_cap_regs
  import pm_cap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic global_reset_n_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  output logic [15:0] pm_caps_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  resp_state_t state_ff;
  resp_state_t nxt_state;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] caps_ff;
  logic [15:0] nxt_caps;
  logic [15:0] caps_word;
  logic take;
  logic hit;
  logic cold_val;
  logic any_reset;

  cold_wake_if cw_if ();

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------

  // One dword holds all three registers; byte lanes pick them apart
  assign hit = (cfg_addr_i[7:2] == CAP_ID_OFFSET[7:2]);
  // Taken only while idle and out of reset, so a write under reset cannot reach bit 15
  assign take = (state_ff == ST_IDLE) && (cfg_rd_i || cfg_wr_i) && !any_reset;
  // The responder restarts on either reset so no stale answer leaks out
  assign any_reset = rst_i || !global_reset_n_i;

  // Only the byte lane holding bit 15 reaches storage
  assign cw_if.wr_en = take && cfg_wr_i && hit && cfg_be_i[COLD_WAKE_BE];
  assign cw_if.wr_val = cfg_wdata_i[COLD_WAKE_DW_BIT];
  assign cold_val = cw_if.value;

  // ----------------------------------------------------------------
  // Cold-wake storage, kept apart because of its own reset
  // ----------------------------------------------------------------
  cold_wake_store u_cold (
    .clk_i (clk_i),
    .global_reset_n_i (global_reset_n_i),
    .cw (cw_if.store)
  );

  // ----------------------------------------------------------------
  // Capabilities word assembly
  // ----------------------------------------------------------------

  // Every field except bit 15 and bit 4, which follows it, is a constant, so writes cannot touch them
  always_comb
  begin
    caps_word = '0;
    caps_word[COLD_WAKE_BIT] = cold_val;
    caps_word[WAKE_FIXED_LSB +: 4] = WAKE_FIXED_VAL;
    caps_word[STATE_TWO_BIT] = STATE_TWO_SUPPORTED;
    caps_word[STATE_ONE_BIT] = STATE_ONE_SUPPORTED;
    caps_word[RSVD_LSB +: 3] = RSVD_VAL;
    caps_word[INIT_NEEDED_BIT] = INIT_NEEDED_VAL;
    // Aux need is meaningless without cold-D3 wake, so it is masked
    caps_word[AUX_SUPPLY_BIT] = AUX_SUPPLY_NEEDED & cold_val;
    caps_word[BUS_CLOCK_BIT] = WAKE_NEEDS_BUS_CLOCK;
    caps_word[VERSION_LSB +: 3] = VERSION_VAL;
  end

  // ----------------------------------------------------------------
  // Responder state machine
  // ----------------------------------------------------------------

  // Each taken request earns exactly one answer cycle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ack = 1'h0;
    case (state_ff)
      ST_IDLE:
      begin
        if (take)
        begin
          nxt_state = ST_ANSWER;
          nxt_ack = 1'h1;
        end
      end
      ST_ANSWER:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Responder registers
  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      state_ff <= ST_IDLE;
      ack_ff <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      ack_ff <= nxt_ack;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Data are sampled at the take edge, before a same-access write lands
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (take)
    begin
      nxt_rdata = '0;
      if (cfg_rd_i && hit)
      begin
        nxt_rdata[CAP_ID_LSB +: 8] = CAP_ID_RESET;
        nxt_rdata[NEXT_LINK_LSB +: 8] = NEXT_LINK_RESET;
        nxt_rdata[PM_CAPS_LSB +: 16] = caps_word;
      end
    end
  end

  // Read data register; cleared by reset so the bus never sees junk
  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Capabilities mirror for the power logic
  // ----------------------------------------------------------------

  // The mirror lags storage by one cycle; only global reset reloads it
  always_comb
  begin
    nxt_caps = caps_word;
  end

  // Mirror register
  always_ff @(posedge clk_i)
  begin
    if (!global_reset_n_i)
    begin
      caps_ff <= PM_CAPS_RESET;
    end
    else
    begin
      caps_ff <= nxt_caps;
    end
  end

  assign cfg_ack_o = ack_ff;
  assign cfg_rdata_o = rdata_ff;
  assign pm_caps_o = caps_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_id_read;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit) |=> cfg_ack_o && (cfg_rdata_o[7:0] == 8'h01);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identifier byte read wrong");

  property p_link_read;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit) |=> (cfg_rdata_o[15:8] == 8'h00);
  endproperty
  a_link_read: assert property (p_link_read)
    else $error("next link byte not zero");

  property p_caps_default;
    @(posedge clk_i) disable iff (rst_i)
    !global_reset_n_i ##1 global_reset_n_i |-> (pm_caps_o == 16'hFE12) ##1 (pm_caps_o == 16'hFE12);
  endproperty
  a_caps_default: assert property (p_caps_default)
    else $error("capabilities word not at default after global reset");

  property p_mask_ones;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit && cold_val && !cfg_wr_i) |=> (cfg_rdata_o[31:27] == 5'h1F);
  endproperty
  a_mask_ones: assert property (p_mask_ones)
    else $error("wake mask not all ones");

  property p_fixed_wake;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    pm_caps_o[14:11] == 4'hF;
  endproperty
  a_fixed_wake: assert property (p_fixed_wake)
    else $error("fixed wake bits not ones");

  property p_state_two;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    pm_caps_o[10];
  endproperty
  a_state_two: assert property (p_state_two)
    else $error("State_two_supported bit low");

  property p_state_one;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    (take && cfg_rd_i && hit) |=> cfg_rdata_o[25] && pm_caps_o[9];
  endproperty
  a_state_one: assert property (p_state_one)
    else $error("State_one_supported bit low");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit) |=> (cfg_rdata_o[24:22] == 3'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");

  property p_init_zero;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    !pm_caps_o[5];
  endproperty
  a_init_zero: assert property (p_init_zero)
    else $error("initialization bit set");

  property p_aux_masked;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit && !cold_val) |=> !cfg_rdata_o[20] && !cfg_rdata_o[31];
  endproperty
  a_aux_masked: assert property (p_aux_masked)
    else $error("aux bit set while cold wake bit clear");

  property p_clk_zero;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit) |=> !cfg_rdata_o[19];
  endproperty
  a_clk_zero: assert property (p_clk_zero)
    else $error("bus clock bit set");

  property p_version;
    @(posedge clk_i) disable iff (any_reset)
    (take && cfg_rd_i && hit) |=> (cfg_rdata_o[18:16] == 3'h2) ##1 (pm_caps_o[2:0] == 3'h2);
  endproperty
  a_version: assert property (p_version)
    else $error("version field wrong");

  property p_ro_write;
    @(posedge clk_i) disable iff (any_reset)
    // Bit 4 legally follows bit 15, so only the truly fixed bits are compared
    (take && cfg_wr_i && !cfg_rd_i) |=> cfg_ack_o && !cw_if.wr_en ##1
      (pm_caps_o[14:5] == $past(pm_caps_o[14:5], 2)) &&
      (pm_caps_o[3:0] == $past(pm_caps_o[3:0], 2));
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write disturbed read-only bits or went unanswered");

  property p_one_answer;
    @(posedge clk_i) disable iff (any_reset)
    cfg_ack_o |=> !cfg_ack_o;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("answer lasted more than one cycle");

endmodule

`default_nettype wire

/* rtl/pm_cap_pkg.sv */
package pm_cap_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_ID_OFFSET = 8'hA0;
  localparam logic [7:0] NEXT_LINK_OFFSET = 8'hA1;
  localparam logic [7:0] PM_CAPS_OFFSET = 8'hA2;

  // Bit position of each register inside the configuration dword
  localparam int CAP_ID_LSB = 8 * int'(CAP_ID_OFFSET[1:0]);
  localparam int NEXT_LINK_LSB = 8 * int'(NEXT_LINK_OFFSET[1:0]);
  localparam int PM_CAPS_LSB = 8 * int'(PM_CAPS_OFFSET[1:0]);

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_ID_RESET = 8'h01;
  localparam logic [7:0] NEXT_LINK_RESET = 8'h00;
  localparam logic [15:0] PM_CAPS_RESET = 16'hFE12;
  localparam logic COLD_WAKE_RESET = 1'h1;
  localparam logic [3:0] WAKE_FIXED_VAL = 4'hF;
  localparam logic STATE_TWO_SUPPORTED = 1'h1;
  localparam logic STATE_ONE_SUPPORTED = 1'h1;
  localparam logic [2:0] RSVD_VAL = 3'h0;
  localparam logic INIT_NEEDED_VAL = 1'h0;
  localparam logic AUX_SUPPLY_NEEDED = 1'h1;
  localparam logic WAKE_NEEDS_BUS_CLOCK = 1'h0;
  localparam logic [2:0] VERSION_VAL = 3'h2;

  // ----------------------------------------------------------------
  // Field positions inside the capabilities word
  // ----------------------------------------------------------------
  localparam int COLD_WAKE_BIT = 15;
  localparam int WAKE_FIXED_LSB = 11;
  localparam int STATE_TWO_BIT = 10;
  localparam int STATE_ONE_BIT = 9;
  localparam int RSVD_LSB = 6;
  localparam int INIT_NEEDED_BIT = 5;
  localparam int AUX_SUPPLY_BIT = 4;
  localparam int BUS_CLOCK_BIT = 3;
  localparam int VERSION_LSB = 0;

  // Dword bit and byte enable that carry the writable bit
  localparam int COLD_WAKE_DW_BIT = PM_CAPS_LSB + COLD_WAKE_BIT;
  localparam int COLD_WAKE_BE = COLD_WAKE_DW_BIT / 8;

  // Access responder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } resp_state_t;

endpackage

/* rtl/cold_wake_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Link between the register decoder and the cold-wake bit store
// ------------------------------------------------------------------
interface cold_wake_if;
  logic wr_en;
  logic wr_val;
  logic value;

  modport ctrl (output wr_en, output wr_val, input value);
  modport store (input wr_en, input wr_val, output value);
endinterface

`default_nettype wire

/* rtl/cold_wake_store.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Cold-wake advertisement bit, kept across ordinary resets
// ------------------------------------------------------------------
module cold_wake_store
  import pm_cap_pkg::*;
(
  input wire logic clk_i,
  input wire logic global_reset_n_i,
  cold_wake_if.store cw
);

  logic cold_ff;
  logic nxt_cold;

  // Only a write changes the bit; the ordinary reset never reaches here
  always_comb
  begin
    nxt_cold = cold_ff;
    if (cw.wr_en)
    begin
      nxt_cold = cw.wr_val;
    end
  end

  // Global reset alone restores the default, so firmware's choice survives
  always_ff @(posedge clk_i)
  begin
    if (!global_reset_n_i)
    begin
      cold_ff <= COLD_WAKE_RESET;
    end
    else
    begin
      cold_ff <= nxt_cold;
    end
  end

  assign cw.value = cold_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cold_write;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    cw.wr_en |=> (cw.value == $past(cw.wr_val));
  endproperty
  a_cold_write: assert property (p_cold_write)
    else $error("cold wake bit did not take written value");

  property p_cold_hold;
    @(posedge clk_i) disable iff (!global_reset_n_i)
    (global_reset_n_i && !cw.wr_en) |=> $stable(cw.value);
  endproperty
  a_cold_hold: assert property (p_cold_hold)
    else $error("cold wake bit changed without write or global reset");

  property p_cold_default;
    @(posedge clk_i)
    !global_reset_n_i |=> (cw.value == COLD_WAKE_RESET);
  endproperty
  a_cold_default: assert property (p_cold_default)
    else $error("cold wake bit not restored by global reset");

endmodule

`default_nettype wire

/* bench/cfg_host.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Configuration host model
// ----------------------------------------------------------------
module cfg_host
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  output var logic rd_o,
  output var logic wr_o,
  output var logic [7:0] addr_o,
  output var logic [3:0] be_o,
  output var logic [31:0] wdata_o
);
  // Quiet bus at time zero
  initial
  begin
    rd_o = 1'h0;
    wr_o = 1'h0;
    addr_o = 8'h00;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end

  // One access; called just after a rising edge, returns one cycle after the answer
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] addr,
    input logic [3:0] be, input logic [31:0] wdata, output logic [31:0] rdata,
    output bit ok);
    int n;
    ok = 1'h0;
    rdata = 32'h0;
    rd_o = rd;
    wr_o = wr;
    addr_o = addr;
    be_o = be;
    wdata_o = wdata;
    @(posedge clk_i);
    #1;
    // Pulse only: a request still high in the answer cycle would be dropped
    rd_o = 1'h0;
    wr_o = 1'h0;
    // Released lines must not keep showing the old value
    addr_o = ~addr;
    be_o = ~be;
    wdata_o = ~wdata;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (ack_i === 1'h1)
      begin
        ok = 1'h1;
        rdata = rdata_i;
      end
      else
      begin
        @(posedge clk_i);
        #1;
      end
    end
    // Let the answer cycle pass so the next request is not refused
    @(posedge clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

/* bench/tb_pm_cap_header.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_pm_cap_regs;
  logic clk_i, rst_i, global_reset_n_i, cfg_rd_i, cfg_wr_i, cfg_ack_o;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  logic [15:0] pm_caps_o;
  logic cold;
  logic [7:0] a;
  int n_mismatch = 0;
  int check_count = 0;
  int i, op;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  pm_cap_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .global_reset_n_i(global_reset_n_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .pm_caps_o(pm_caps_o));

  cfg_host i_host (.clk_i(clk_i), .ack_i(cfg_ack_o), .rdata_i(cfg_rdata_o), .rd_o(cfg_rd_i),
    .wr_o(cfg_wr_i), .addr_o(cfg_addr_i), .be_o(cfg_be_i), .wdata_o(cfg_wdata_i));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  // Aux-supply bit follows the cold-wake bit, so both come from one flag
  function automatic logic [15:0] exp_caps(input logic c);
    exp_caps = {c, 4'hF, 1'h1, 1'h1, 3'h0, 1'h0, c, 1'h0, 3'h2};
  endfunction

  function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic c);
    exp_rd = (ad[7:2] == 6'h28) ? {exp_caps(c), 8'h00, 8'h01} : 32'h0;
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // Read data is the value before any write of the same access
  task automatic acc(input logic rd, input logic wr, input logic [7:0] ad,
    input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] got;
    logic [31:0] exp;
    bit ok;
    exp = rd ? exp_rd(ad, cold) : 32'h0;
    if (wr && ad[7:2] == 6'h28 && be[3])
      cold = wd[31];
    i_host.xfer(rd, wr, ad, be, wd, got, ok);
    if (!ok)
    begin
      $display("[ERR] cfg_ack_o expected 1 seen 0");
      n_mismatch++;
      end_sim();
    end
    chk("cfg_rdata_o", exp, got);
    chk("pm_caps_o", {16'h0, exp_caps(cold)}, {16'h0, pm_caps_o});
  endtask

  // Synchronous reset pulse of one edge on either input
  task automatic pulse(input bit global);
    if (global)
      global_reset_n_i = 1'h0;
    else
      rst_i = 1'h1;
    @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    global_reset_n_i = 1'h1;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1'h1;
    global_reset_n_i = 1'h0;
    cold = 1'h1;
    void'($urandom(40876));
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    global_reset_n_i = 1'h1;
    // Defaults, fixed fields, every lane address of the dword
    for (i = 0; i < 4; i++)
      acc(1'h1, 1'h0, 8'hA0 + 8'(i), 4'hF, 32'h0);
    // Read-only bits ignore all-ones, with lane 3 off too
    acc(1'h0, 1'h1, 8'hA0, 4'h7, 32'hFFFFFFFF);
    acc(1'h0, 1'h1, 8'hA1, 4'hF, 32'hFFFFFFFF);
    acc(1'h1, 1'h0, 8'hA0, 4'hF, 32'h0);
    // Firmware without aux supply clears cold-wake
    acc(1'h0, 1'h1, 8'hA2, 4'h8, 32'h7FFFFFFF);
    acc(1'h1, 1'h0, 8'hA0, 4'hF, 32'h0);
    // Ordinary reset keeps the cleared bit
    pulse(1'h0);
    chk("pm_caps_o", 32'h00007E02, {16'h0, pm_caps_o});
    acc(1'h1, 1'h0, 8'hA3, 4'hF, 32'h0);
    // Global reset brings it back
    pulse(1'h1);
    cold = 1'h1;
    chk("pm_caps_o", 32'h0000FE12, {16'h0, pm_caps_o});
    acc(1'h1, 1'h0, 8'hA0, 4'hF, 32'h0);
    // Read and write together, then set again
    acc(1'h1, 1'h1, 8'hA0, 4'h8, 32'h0);
    acc(1'h1, 1'h1, 8'hA0, 4'hF, 32'hFFFFFFFF);
    acc(1'h1, 1'h0, 8'hA0, 4'hF, 32'h0);
    // Unmapped places read zero and keep the bit
    acc(1'h0, 1'h1, 8'hA4, 4'hF, 32'h0);
    acc(1'h1, 1'h0, 8'h9F, 4'hF, 32'h0);
    // Random mix of reads, writes and misses
    for (i = 0; i < 60; i++)
    begin
      op = $urandom % 3;
      a = ($urandom % 2) ? 8'hA0 + 8'($urandom % 4) : 8'($urandom);
      acc(op != 1, op != 0, a, 4'($urandom), 32'($urandom));
    end
    end_sim();
  end
endmodule

`default_nettype wire
